// *** rtl/pdm_pkg.sv ***
// constants for the program and data memory map decoder
package pdm_pkg;
	localparam int PDM_PC_W = 13;
	localparam int PDM_ROM_AW = 10;
	localparam logic [12:0] PDM_RESET_VEC = 13'h0000;
	localparam logic [12:0] PDM_IRQ_VEC = 13'h0004;
	localparam logic [7:0] PDM_SFR_TOP = 8'h1f;
	localparam logic [6:0] PDM_GPR_LO = 7'h20;
	localparam logic [6:0] PDM_GPR_HI = 7'h5f;
	localparam int PDM_GPR_DEPTH = 64;
	localparam int PDM_BANK_BIT = 5;
	localparam logic [7:0] PDM_RST_STATUS = 8'h18;
	localparam logic [7:0] PDM_RST_ZERO = 8'h00;
	localparam logic [7:0] PDM_ADDR_WINDOW = 8'h00;
	localparam logic [7:0] PDM_ADDR_TIMER_ZERO = 8'h01;
	localparam logic [7:0] PDM_ADDR_PROG_LOW = 8'h02;
	localparam logic [7:0] PDM_ADDR_STATUS = 8'h03;
	localparam logic [7:0] PDM_ADDR_POINTER = 8'h04;
	localparam logic [7:0] PDM_ADDR_PORT_A_LEVEL = 8'h05;
	localparam logic [7:0] PDM_ADDR_PORT_C_LEVEL = 8'h07;
	localparam logic [7:0] PDM_ADDR_PROG_HIGH_LATCH = 8'h0a;
	localparam logic [7:0] PDM_ADDR_IRQ_CONTROL = 8'h0b;
	localparam logic [7:0] PDM_ADDR_PERIPH_FLAGS = 8'h0c;
	localparam logic [7:0] PDM_ADDR_TIMER_ONE_LOW = 8'h0e;
	localparam logic [7:0] PDM_ADDR_TIMER_ONE_HIGH = 8'h0f;
	localparam logic [7:0] PDM_ADDR_TIMER_ONE_CTRL = 8'h10;
	localparam logic [7:0] PDM_ADDR_COMPARATOR = 8'h19;
	localparam logic [7:0] PDM_ADDR_CONV_HIGH = 8'h1e;
	localparam logic [7:0] PDM_ADDR_CONV_CTRL_A = 8'h1f;
	localparam logic [7:0] PDM_ADDR_OPTIONS = 8'h81;
	localparam logic [7:0] PDM_ADDR_PORT_A_DIR = 8'h85;
	localparam logic [7:0] PDM_ADDR_PORT_C_DIR = 8'h87;
	localparam logic [7:0] PDM_ADDR_PERIPH_ENABLES = 8'h8c;
	localparam logic [7:0] PDM_ADDR_POWER_EVENTS = 8'h8e;
	localparam logic [7:0] PDM_ADDR_OSC_TRIM = 8'h90;
	localparam logic [7:0] PDM_ADDR_ANALOG_SELECT = 8'h91;
	localparam logic [7:0] PDM_ADDR_PULLUPS = 8'h95;
	localparam logic [7:0] PDM_ADDR_CHANGE_IRQ = 8'h96;
	localparam logic [7:0] PDM_ADDR_VREF_CTRL = 8'h99;
	localparam logic [7:0] PDM_ADDR_NVM_DATA = 8'h9a;
	localparam logic [7:0] PDM_ADDR_NVM_ADDRESS = 8'h9b;
	localparam logic [7:0] PDM_ADDR_NVM_CONTROL = 8'h9c;
	localparam logic [7:0] PDM_ADDR_NVM_UNLOCK = 8'h9d;
	localparam logic [7:0] PDM_ADDR_CONV_LOW = 8'h9e;
	localparam logic [7:0] PDM_ADDR_CONV_CTRL_B = 8'h9f;
endpackage

// *** rtl/pdm_memory_map.sv ***
// program counter and data memory decoder of the small core
//
// Function
// RL1: a 13-bit program counter spans an 8K word program space.
// RL2: only words 0000h-03FFh exist and higher fetch addresses wrap modulo 1K.
// RL3: reset starts at word 0000h and an accepted interrupt loads 0004h.
// RL4: data memory has two banks, each with 32 special function locations at the bottom.
// RL5: file addresses 20h-5Fh hit one shared general RAM seen from both banks.
// RL6: unmapped data addresses read zero and drop writes.
// RL7: bit five of the flags register picks bank 0 when clear and bank 1 when set.
// RL8: the general RAM has 64 bytes reachable directly and through the pointer.
// RL9: special function locations are static storage that hold their value.
// RL10: the indirect window location redirects to the address in the pointer.
// RL11: a direct address is the 7-bit file address with the bank bit on top.
`timescale 1ns/1ns
`default_nettype none
module pdm_memory_map
	import pdm_pkg::*;
#(
	parameter int GPR_DEPTH = PDM_GPR_DEPTH
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic pc_step,
	input wire logic pc_load,
	input wire logic [10:0] pc_load_addr,
	input wire logic irq_accept,
	output logic [12:0] pc,
	output logic [9:0] rom_addr,
	input wire logic [6:0] file_addr,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic [7:0] flags,
	output logic [7:0] pointer
);

	////////////////////////////////////////////////////////////////////////
	// program side state
	logic [12:0] pc_r;
	logic [7:0] pc_latch_r;

	// core registers seen from both banks
	logic [7:0] flags_r;
	logic [7:0] pointer_r;

	// static storage
	logic [7:0] sfr_r [0:63];
	logic [7:0] gpr_r [0:GPR_DEPTH-1];

	// read path
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;

	// decoded access
	logic [7:0] eff_addr;
	logic [5:0] sfr_idx;
	logic [5:0] gpr_idx;
	logic is_gpr;
	logic is_sfr;
	logic is_core;

	// write strobes, one per storage concern
	logic pc_low_wr;
	logic flags_wr;
	logic pointer_wr;
	logic pc_latch_wr;
	logic sfr_wr;
	logic gpr_wr;

	// classify a full data address into shared ram or special location
	function automatic logic gpr_hit(input logic [7:0] a);
		gpr_hit = (a[6:0] >= PDM_GPR_LO) && (a[6:0] <= PDM_GPR_HI); // RL5
	endfunction

	function automatic logic sfr_hit(input logic [7:0] a);
		sfr_hit = (a[6:0] <= PDM_SFR_TOP[6:0]) && (a[6:0] != PDM_ADDR_WINDOW[6:0]); // RL4
	endfunction

	// locations that reach the same register from either bank
	function automatic logic shared_hit(input logic [7:0] a);
		shared_hit = 1'b0;
		if (a[6:0] == PDM_ADDR_PROG_LOW[6:0]) begin
			shared_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_STATUS[6:0]) begin
			shared_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_POINTER[6:0]) begin
			shared_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_PROG_HIGH_LATCH[6:0]) begin
			shared_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_IRQ_CONTROL[6:0]) begin
			shared_hit = 1'b1;
		end
	endfunction

	// core registers that live in dedicated flops rather than the array
	function automatic logic core_hit(input logic [7:0] a);
		core_hit = 1'b0;
		if (a[6:0] == PDM_ADDR_PROG_LOW[6:0]) begin
			core_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_STATUS[6:0]) begin
			core_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_POINTER[6:0]) begin
			core_hit = 1'b1;
		end else if (a[6:0] == PDM_ADDR_PROG_HIGH_LATCH[6:0]) begin
			core_hit = 1'b1;
		end
	endfunction

	// implemented special locations; the gaps between them read as zero
	function automatic logic sfr_present(input logic [7:0] a);
		sfr_present = 1'b0;
		if (shared_hit(a)) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_TIMER_ZERO) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PORT_A_LEVEL) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PORT_C_LEVEL) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PERIPH_FLAGS) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_TIMER_ONE_LOW) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_TIMER_ONE_HIGH) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_TIMER_ONE_CTRL) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_COMPARATOR) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_CONV_HIGH) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_CONV_CTRL_A) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_OPTIONS) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PORT_A_DIR) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PORT_C_DIR) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PERIPH_ENABLES) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_POWER_EVENTS) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_OSC_TRIM) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_ANALOG_SELECT) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_PULLUPS) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_CHANGE_IRQ) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_VREF_CTRL) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_NVM_DATA) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_NVM_ADDRESS) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_NVM_CONTROL) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_NVM_UNLOCK) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_CONV_LOW) begin
			sfr_present = 1'b1;
		end else if (a == PDM_ADDR_CONV_CTRL_B) begin
			sfr_present = 1'b1;
		end
	endfunction

	// array slot: shared locations fold onto bank 0 so both banks agree
	function automatic logic [5:0] sfr_slot(input logic [7:0] a);
		if (shared_hit(a)) begin
			sfr_slot = {1'b0, a[4:0]};
		end else begin
			sfr_slot = {a[7], a[4:0]};
		end
	endfunction

	// result registers are filled by their peripheral, so core writes drop
	function automatic logic read_only_hit(input logic [7:0] a);
		read_only_hit = 1'b0;
		if (a == PDM_ADDR_CONV_HIGH) begin
			read_only_hit = 1'b1;
		end else if (a == PDM_ADDR_CONV_LOW) begin
			read_only_hit = 1'b1;
		end
	endfunction

	// the unlock location holds no readable value
	function automatic logic write_only_hit(input logic [7:0] a);
		write_only_hit = 1'b0;
		if (a == PDM_ADDR_NVM_UNLOCK) begin
			write_only_hit = 1'b1;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// effective address: window goes through pointer, else bank bit on top
	always_comb begin
		if (file_addr == PDM_ADDR_WINDOW[6:0]) begin
			eff_addr = pointer_r; // RL10
		end else begin
			eff_addr = {flags_r[PDM_BANK_BIT], file_addr}; // RL11 RL7
		end
		is_gpr = gpr_hit(eff_addr);
		is_sfr = sfr_hit(eff_addr) && sfr_present(eff_addr); // RL6
		is_core = is_sfr && core_hit(eff_addr);
		sfr_idx = sfr_slot(eff_addr);
		gpr_idx = 6'(eff_addr[6:0] - PDM_GPR_LO); // RL5
	end

	// write strobes; unmapped or read-only targets raise none of them
	assign pc_low_wr = wr_en && is_core && (eff_addr[6:0] == PDM_ADDR_PROG_LOW[6:0]);
	assign flags_wr = wr_en && is_core && (eff_addr[6:0] == PDM_ADDR_STATUS[6:0]);
	assign pointer_wr = wr_en && is_core && (eff_addr[6:0] == PDM_ADDR_POINTER[6:0]);
	assign pc_latch_wr = wr_en && is_core && (eff_addr[6:0] == PDM_ADDR_PROG_HIGH_LATCH[6:0]);
	assign sfr_wr = wr_en && is_sfr && !is_core && !read_only_hit(eff_addr); // RL6
	assign gpr_wr = wr_en && is_gpr;

	////////////////////////////////////////////////////////////////////////
	// program counter
	always_ff @(posedge mclk) begin
		if (reset) begin
			pc_r <= PDM_RESET_VEC; // RL3
		end else if (irq_accept) begin
			pc_r <= PDM_IRQ_VEC; // RL3
		end else if (pc_load) begin
			pc_r <= {pc_latch_r[4:3], pc_load_addr};
		end else if (pc_low_wr) begin
			pc_r <= {pc_latch_r[4:0], wr_data};
		end else if (pc_step) begin
			pc_r <= pc_r + 13'h0001; // RL1
		end
	end

	assign pc = pc_r;
	assign rom_addr = pc_r[PDM_ROM_AW-1:0]; // RL2

	////////////////////////////////////////////////////////////////////////
	// flags register, holds the bank bit
	always_ff @(posedge mclk) begin
		if (reset) begin
			flags_r <= PDM_RST_STATUS;
		end else if (flags_wr) begin
			flags_r <= wr_data; // RL7
		end
	end

	// indirect pointer, shared by both banks
	always_ff @(posedge mclk) begin
		if (reset) begin
			pointer_r <= PDM_RST_ZERO;
		end else if (pointer_wr) begin
			pointer_r <= wr_data; // RL10
		end
	end

	// upper program counter latch, only five bits exist
	always_ff @(posedge mclk) begin
		if (reset) begin
			pc_latch_r <= PDM_RST_ZERO;
		end else if (pc_latch_wr) begin
			pc_latch_r <= {3'h0, wr_data[4:0]};
		end
	end

	// other special locations: static, per bank unless shared
	always_ff @(posedge mclk) begin
		if (sfr_wr) begin
			sfr_r[sfr_idx] <= wr_data; // RL9
		end
	end

	// shared general ram, bank bit ignored
	always_ff @(posedge mclk) begin
		if (gpr_wr) begin
			gpr_r[gpr_idx] <= wr_data; // RL8 RL5
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data select, zero outside mapped space, holds between reads
	always_comb begin
		rd_data_nxt = rd_data_r;
		if (rd_en) begin
			if (is_gpr) begin
				rd_data_nxt = gpr_r[gpr_idx]; // RL8
			end else if (is_core && eff_addr[6:0] == PDM_ADDR_PROG_LOW[6:0]) begin
				rd_data_nxt = pc_r[7:0];
			end else if (is_core && eff_addr[6:0] == PDM_ADDR_STATUS[6:0]) begin
				rd_data_nxt = flags_r;
			end else if (is_core && eff_addr[6:0] == PDM_ADDR_POINTER[6:0]) begin
				rd_data_nxt = pointer_r;
			end else if (is_core) begin
				rd_data_nxt = pc_latch_r;
			end else if (is_sfr && !write_only_hit(eff_addr)) begin
				rd_data_nxt = sfr_r[sfr_idx]; // RL9
			end else begin
				rd_data_nxt = 8'h00; // RL6
			end
		end
	end

	// read data register
	always_ff @(posedge mclk) begin
		if (reset) begin
			rd_data_r <= 8'h00;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign flags = flags_r;
	assign pointer = pointer_r;

endmodule
`default_nettype wire

// *** verification/pdm_memory_map_monitor.sv ***
// port assertions for the memory map decoder
`timescale 1ns/1ns
`default_nettype none
module pdm_memory_map_monitor (
	input wire logic mclk,
	input wire logic reset,
	input wire logic pc_step,
	input wire logic pc_load,
	input wire logic irq_accept,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [10:0] pc_load_addr,
	input wire logic [12:0] pc,
	input wire logic [9:0] rom_addr,
	input wire logic [6:0] file_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] flags,
	input wire logic [7:0] pointer
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// program side
	AST_ROM: assert property (rom_addr == pc[9:0]) else $error("rom");
	AST_RST: assert property ($fell(reset) |-> pc == 13'h0000) else $error("rst");
	AST_IRQ: assert property (irq_accept |=> pc == 13'h0004) else $error("irq");
	AST_LOAD: assert property (pc_load && !irq_accept |=> pc[10:0] == $past(pc_load_addr))
		else $error("load");
	AST_STEP: assert property (pc_step && !(pc_load || irq_accept || wr_en)
		|=> pc == $past(pc) + 13'h1) else $error("step");
	// data side
	AST_PTR: assert property (wr_en && file_addr == 7'h04 |=> pointer == $past(wr_data))
		else $error("ptr");
	AST_HOLD: assert property (!wr_en |=> $stable(pointer)) else $error("hold");
	AST_ZERO: assert property (rd_en && file_addr[6:5] == 2'b11 |=> rd_data == 8'h00)
		else $error("zero");
	// main scenarios
	cover property (irq_accept);
	cover property (rd_en && file_addr == 7'h00);
	cover property (wr_en && file_addr == 7'h02);
endmodule
`default_nettype wire

// *** verification/pdm_core_model.sv ***
// core fetch stepper that advances the program counter
`timescale 1ns/1ns
`default_nettype none
module pdm_core_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic run,
	output logic pc_step
);
	// one step per cycle while running, launched just after the edge
	initial pc_step = 1'b0;
	always @(posedge mclk) pc_step <= #1 run && !reset;
endmodule
`default_nettype wire

// *** verification/test_pdm_memory_map.sv ***
// self-checking bench for the memory map decoder
`timescale 1ns/1ns
`default_nettype none
module test_pdm_memory_map;
	logic mclk = 0, reset = 1, pc_load = 0, irq_accept = 0, rd_en = 0, wr_en = 0, run = 0;
	logic pc_step;
	logic [10:0] pc_load_addr = 11'h7ff;
	logic [6:0] file_addr = 7'h00;
	logic [7:0] wr_data = 8'h00, rd_data, flags, pointer;
	logic [12:0] pc;
	logic [9:0] rom_addr;
	int n_fail = 0, n_checks = 0, cycles = 0;
	// write flag, file address, data or expected read value
	logic [16:0] ops [18] = '{17'h120a5, 17'h105c3, 17'h10320, 17'h1053c, 17'h020a5,
		17'h0053c, 17'h10300, 17'h005c3, 17'h160ff, 17'h06000, 17'h104a0, 17'h000a5,
		17'h10400, 17'h00000, 17'h10677, 17'h00600, 17'h10a18, 17'h10240};
	pdm_memory_map u_dut (.mclk(mclk), .reset(reset), .pc_step(pc_step), .pc_load(pc_load),
		.pc_load_addr(pc_load_addr), .irq_accept(irq_accept), .pc(pc), .rom_addr(rom_addr),
		.file_addr(file_addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
		.rd_data(rd_data), .flags(flags), .pointer(pointer));
	pdm_core_model u_core (.mclk(mclk), .reset(reset), .run(run), .pc_step(pc_step));
	// clock and hang guard
	always #25 mclk = ~mclk;
	always @(posedge mclk) if (++cycles == 400) begin n_fail++; wrap_up(); end
	task automatic cyc(); @(posedge mclk); #1; endtask
	task automatic chk(logic [12:0] got, logic [12:0] exp);
		n_checks++;
		if (got !== exp) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end
	endtask
	task automatic acc(logic w, logic [6:0] a, logic [7:0] d);
		file_addr = a; wr_data = d; wr_en = w; rd_en = !w;
		cyc(); wr_en = 0; rd_en = 0; cyc();
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) cyc();
		reset = 0;
		cyc();
		chk(pc, 13'h0000);
		foreach (ops[i]) begin
			acc(ops[i][16], ops[i][14:8], ops[i][7:0]);
			if (!ops[i][16]) chk(13'(rd_data), 13'(ops[i][7:0]));
		end
		chk(pc, 13'h1840);
		chk(13'(flags), 13'h0000);
		chk(13'(pointer), 13'h0000);
		pc_load = 1;
		cyc();
		pc_load = 0;
		run = 1;
		chk(13'(rom_addr), 13'h3ff);
		cyc();
		run = 0;
		cyc();
		chk(pc, 13'h0000);
		irq_accept = 1;
		cyc();
		irq_accept = 0;
		chk(pc, 13'h0004);
		wrap_up();
	end
endmodule
bind pdm_memory_map pdm_memory_map_monitor u_mon (.mclk(mclk), .reset(reset),
	.pc_step(pc_step), .pc_load(pc_load), .irq_accept(irq_accept), .rd_en(rd_en),
	.wr_en(wr_en), .pc_load_addr(pc_load_addr), .pc(pc), .rom_addr(rom_addr),
	.file_addr(file_addr), .wr_data(wr_data), .rd_data(rd_data), .flags(flags),
	.pointer(pointer));
`default_nettype wire
